/* src/vref_map.svh */
// Register map, field positions, reset values and timing counts
// for the voltage reference control block.
// Assumes a byte-wide register port with a two-bit address.
`ifndef VREF_MAP_SVH
`define VREF_MAP_SVH

// ==========================================================
// Register addresses
`define VREF_ADDR_FIXED 2'h0
`define VREF_ADDR_LADDER 2'h1
`define VREF_ADDR_LEVEL 2'h2

// ==========================================================
// Fixed reference control fields
`define VREF_FIX_EN_BIT 7
`define VREF_FIX_STABLE_BIT 6
`define VREF_FIX_GAIN_HI 5
`define VREF_FIX_GAIN_LO 4
`define VREF_FIX_GAIN_RESET 2'h1

// ==========================================================
// Ladder control fields
`define VREF_LAD_EN_BIT 7
`define VREF_LAD_LPS_BIT 6
`define VREF_LAD_OE_BIT 5
`define VREF_LAD_PSS_HI 3
`define VREF_LAD_PSS_LO 2
`define VREF_LAD_NSS_BIT 0

// ==========================================================
// Level select fields
`define VREF_LVL_HI 4
`define VREF_LVL_LO 0
`define VREF_LVL_MAX 5'h1F
`define VREF_LVL_MIN 5'h00
`define VREF_LVL_PAD_HI 7
`define VREF_LVL_PAD_LO 5

// ==========================================================
// Timing
`define VREF_CLK_NS 20
`define VREF_SETTLE_NS 25000
`define VREF_SETTLE_CYC \
    ((`VREF_SETTLE_NS + `VREF_CLK_NS - 1) / `VREF_CLK_NS)
`define VREF_CNT_W 11

`endif

/* src/vref_pkg.sv */
// Types shared by the voltage reference control block.
// Assumes the map header is compiled alongside.
package vref_pkg;

    // ======================================================
    // Positive source choices
    typedef enum logic [1:0] {
        POS_SUPPLY = 2'h0,
        POS_EXT_PIN = 2'h1,
        POS_FIXED_REF = 2'h2,
        POS_RESERVED = 2'h3
    } pos_src_t;

    // ======================================================
    // Ladder configuration as stored and driven
    typedef struct packed {
        logic ladder_enable;
        logic low_power_state_select;
        logic ladder_output_enable;
        pos_src_t positive_source_select;
        logic negative_source_select;
    } ladder_cfg_t;

    // Fixed reference configuration as stored and driven
    typedef struct packed {
        logic fixed_ref_enable;
        logic [1:0] fixed_ref_gain_select;
    } fixed_cfg_t;

    // Shared reference pin controls
    typedef struct packed {
        logic analog_drive;
        logic dig_out_disable;
        logic dig_in_disable;
    } pin_ctrl_t;

endpackage

/* src/voltage_reference_control.sv */
// Digital control of the ladder and fixed voltage references.
// Assumes a plain byte register port, one clock, synchronous
// active-low reset; analog parts sit outside on the outputs.
`include "vref_map.svh"

module voltage_reference_control (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic pin_i,
    output logic [7:0] rdata_o,
    output vref_pkg::ladder_cfg_t ladder_cfg_o,
    output logic [4:0] ladder_code_o,
    output vref_pkg::fixed_cfg_t fixed_cfg_o,
    output logic fixed_ref_stable_o,
    output vref_pkg::pin_ctrl_t pin_ctrl_o,
    output logic pin_read_o
);

    // ======================================================
    // Decoding
    function automatic logic hit(input logic [1:0] a,
                                 input logic [1:0] want);
        hit = (a == want);
    endfunction

    logic wr_fixed;
    logic wr_ladder;
    logic wr_level;
    assign wr_fixed = wr_i && hit(addr_i, `VREF_ADDR_FIXED);
    assign wr_ladder = wr_i && hit(addr_i, `VREF_ADDR_LADDER);
    assign wr_level = wr_i && hit(addr_i, `VREF_ADDR_LEVEL);

    // ======================================================
    // Stored registers
    logic [4:0] level;
    logic [`VREF_CNT_W-1:0] settle_cnt;

    // Only reset and writes touch ladder control; a wake
    // from sleep has no path in here at all.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ladder_cfg_o <= '0;
        end else if (wr_ladder) begin
            ladder_cfg_o.ladder_enable <=
                wdata_i[`VREF_LAD_EN_BIT];
            ladder_cfg_o.low_power_state_select <=
                wdata_i[`VREF_LAD_LPS_BIT];
            ladder_cfg_o.ladder_output_enable <=
                wdata_i[`VREF_LAD_OE_BIT];
            ladder_cfg_o.positive_source_select <=
                vref_pkg::pos_src_t'(
                wdata_i[`VREF_LAD_PSS_HI:`VREF_LAD_PSS_LO]);
            // Reserved source code is stored as written
            ladder_cfg_o.negative_source_select <=
                wdata_i[`VREF_LAD_NSS_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            level <= `VREF_LVL_MIN;
        end else if (wr_level) begin
            level <= wdata_i[`VREF_LVL_HI:`VREF_LVL_LO];
        end
    end

    // Stable bit of the written byte is dropped here
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            fixed_cfg_o.fixed_ref_enable <= 1'b0;
            fixed_cfg_o.fixed_ref_gain_select <=
                `VREF_FIX_GAIN_RESET;
        end else if (wr_fixed) begin
            fixed_cfg_o.fixed_ref_enable <=
                wdata_i[`VREF_FIX_EN_BIT];
            fixed_cfg_o.fixed_ref_gain_select <=
                wdata_i[`VREF_FIX_GAIN_HI:`VREF_FIX_GAIN_LO];
        end
    end

    // ======================================================
    // Fixed reference settling
    // The flag is a timer, not a sense of the analog node;
    // software may poll it instead of its own delay.
    always_ff @(posedge clk_i) begin
        if (!resetn_i || !fixed_cfg_o.fixed_ref_enable) begin
            settle_cnt <= '0;
            fixed_ref_stable_o <= 1'b0;
        end else if (settle_cnt ==
                     `VREF_CNT_W'(`VREF_SETTLE_CYC - 1)) begin
            fixed_ref_stable_o <= 1'b1;
        end else begin
            settle_cnt <= settle_cnt + `VREF_CNT_W'(1);
        end
    end

    // ======================================================
    // Ladder level to the analog switch network
    logic [4:0] next_code;
    always_comb begin
        if (ladder_cfg_o.ladder_enable) begin
            next_code = level;
        end else if (ladder_cfg_o.low_power_state_select) begin
            next_code = `VREF_LVL_MAX;
        end else begin
            next_code = `VREF_LVL_MIN;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ladder_code_o <= `VREF_LVL_MIN;
        end else begin
            ladder_code_o <= next_code;
        end
    end

    // ======================================================
    // Shared pin
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic pin_level;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            pin_s3 <= 1'b0;
        end else begin
            pin_s1 <= pin_i;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // Level moves only when the last two stages agree
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pin_level <= 1'b0;
        end else if (pin_s2 == pin_s3) begin
            pin_level <= pin_s3;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pin_ctrl_o <= '0;
            pin_read_o <= 1'b0;
        end else begin
            pin_ctrl_o.analog_drive <=
                ladder_cfg_o.ladder_output_enable;
            pin_ctrl_o.dig_out_disable <=
                ladder_cfg_o.ladder_output_enable;
            pin_ctrl_o.dig_in_disable <=
                ladder_cfg_o.ladder_output_enable;
            pin_read_o <= pin_level &&
                !ladder_cfg_o.ladder_output_enable;
        end
    end

    // ======================================================
    // Read port
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        unique case (addr_i)
            `VREF_ADDR_FIXED: begin
                next_rdata[`VREF_FIX_EN_BIT] =
                    fixed_cfg_o.fixed_ref_enable;
                next_rdata[`VREF_FIX_STABLE_BIT] =
                    fixed_ref_stable_o;
                next_rdata[`VREF_FIX_GAIN_HI:`VREF_FIX_GAIN_LO] =
                    fixed_cfg_o.fixed_ref_gain_select;
            end
            `VREF_ADDR_LADDER: begin
                next_rdata[`VREF_LAD_EN_BIT] =
                    ladder_cfg_o.ladder_enable;
                next_rdata[`VREF_LAD_LPS_BIT] =
                    ladder_cfg_o.low_power_state_select;
                next_rdata[`VREF_LAD_OE_BIT] =
                    ladder_cfg_o.ladder_output_enable;
                next_rdata[`VREF_LAD_PSS_HI:`VREF_LAD_PSS_LO] =
                    ladder_cfg_o.positive_source_select;
                next_rdata[`VREF_LAD_NSS_BIT] =
                    ladder_cfg_o.negative_source_select;
            end
            `VREF_ADDR_LEVEL: begin
                next_rdata[`VREF_LVL_HI:`VREF_LVL_LO] = level;
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    // Data stands only in the cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (!resetn_i || !rd_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= next_rdata;
        end
    end

    // ======================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    property p_ladder_en;
        wr_ladder |=> ladder_cfg_o.ladder_enable ==
            $past(wdata_i[`VREF_LAD_EN_BIT]);
    endproperty
    a_ladder_en: assert property (p_ladder_en)
        else $error("ladder enable not stored");

    sequence s_level_written;
        wr_level && !wr_ladder ##1
            ladder_cfg_o.ladder_enable;
    endsequence
    property p_level_out;
        s_level_written |=> ladder_code_o == $past(level);
    endproperty
    a_level_out: assert property (p_level_out)
        else $error("ladder code does not follow level");

    property p_low_power;
        !ladder_cfg_o.ladder_enable |=> ladder_code_o ==
            ($past(ladder_cfg_o.low_power_state_select) ?
             `VREF_LVL_MAX : `VREF_LVL_MIN);
    endproperty
    a_low_power: assert property (p_low_power)
        else $error("low-power level wrong");

    property p_pos_src;
        wr_ladder |=> ladder_cfg_o.positive_source_select ==
            $past(wdata_i[`VREF_LAD_PSS_HI:`VREF_LAD_PSS_LO]);
    endproperty
    a_pos_src: assert property (p_pos_src)
        else $error("positive source not stored");

    property p_neg_src;
        wr_ladder |=> ladder_cfg_o.negative_source_select ==
            $past(wdata_i[`VREF_LAD_NSS_BIT]);
    endproperty
    a_neg_src: assert property (p_neg_src)
        else $error("negative source not stored");

    property p_pin_drive;
        ladder_cfg_o.ladder_output_enable |=>
            pin_ctrl_o.analog_drive &&
            pin_ctrl_o.dig_out_disable &&
            pin_ctrl_o.dig_in_disable;
    endproperty
    a_pin_drive: assert property (p_pin_drive)
        else $error("pin not handed to ladder");

    property p_pin_zero;
        pin_ctrl_o.analog_drive |-> !pin_read_o;
    endproperty
    a_pin_zero: assert property (p_pin_zero)
        else $error("pin read not zero while driving");

    property p_hold;
        !wr_ladder |=> $stable(ladder_cfg_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("ladder control changed without write");

    // Must see reset itself, so the default disable is overridden
    property p_reset;
        @(posedge clk_i) disable iff (1'b0)
            !resetn_i |=> !ladder_cfg_o.ladder_enable
            && !ladder_cfg_o.ladder_output_enable
            && !pin_ctrl_o.analog_drive
            && !fixed_cfg_o.fixed_ref_enable
            && level == `VREF_LVL_MIN
            && fixed_cfg_o.fixed_ref_gain_select ==
            `VREF_FIX_GAIN_RESET;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset values wrong");

    property p_fixed_en;
        wr_fixed |=> fixed_cfg_o.fixed_ref_enable ==
            $past(wdata_i[`VREF_FIX_EN_BIT]);
    endproperty
    a_fixed_en: assert property (p_fixed_en)
        else $error("fixed enable not stored");

    property p_stable;
        $rose(fixed_cfg_o.fixed_ref_enable) |->
            !fixed_ref_stable_o ##1 !fixed_ref_stable_o;
    endproperty
    a_stable: assert property (p_stable)
        else $error("stable flag set too early");

    property p_stable_drop;
        !fixed_cfg_o.fixed_ref_enable |=> !fixed_ref_stable_o;
    endproperty
    a_stable_drop: assert property (p_stable_drop)
        else $error("stable flag set while disabled");

    property p_unimpl;
        rd_i && hit(addr_i, `VREF_ADDR_LEVEL) |=>
            rdata_o[`VREF_LVL_PAD_HI:`VREF_LVL_PAD_LO] == 3'h0;
    endproperty
    a_unimpl: assert property (p_unimpl)
        else $error("unimplemented bits read nonzero");

endmodule

/* verification/voltage_reference_control_tb.sv */
// Self-checking bench for the voltage reference control block.
// Assumes the design package and map header are compiled first.
module voltage_reference_control_tb;
    timeunit 1ns;
    timeprecision 1ps;

`define CHK(nm, exp, got) begin n_checks++; \
    if ((got) !== (exp)) begin fail_count++; \
        $display("mismatch %s exp %h got %h", nm, exp, got); end end

    // ==========================================================
    // Signals and design
    logic clk_i, resetn_i, wr_i, rd_i, pin_i;
    logic [1:0] addr_i;
    logic [7:0] wdata_i, rdata_o, d;
    vref_pkg::ladder_cfg_t ladder_cfg_o;
    logic [4:0] ladder_code_o;
    vref_pkg::fixed_cfg_t fixed_cfg_o;
    logic fixed_ref_stable_o, pin_read_o;
    vref_pkg::pin_ctrl_t pin_ctrl_o;
    int fail_count, n_checks, cycles;

    voltage_reference_control i_voltage_reference_control (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .pin_i(pin_i),
        .rdata_o(rdata_o),
        .ladder_cfg_o(ladder_cfg_o),
        .ladder_code_o(ladder_code_o),
        .fixed_cfg_o(fixed_cfg_o),
        .fixed_ref_stable_o(fixed_ref_stable_o),
        .pin_ctrl_o(pin_ctrl_o),
        .pin_read_o(pin_read_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // ==========================================================
    // Bus tasks
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        // Let the stored value settle before callers look
        #1;
    endtask

    task automatic rd(input logic [1:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    // Derived outputs trail the stored register by one cycle
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        rd(2'h0);
        `CHK("fixed rd", 8'h10, d)
        rd(2'h1);
        `CHK("ladder rd", 8'h00, d)
        rd(2'h2);
        `CHK("level rd", 8'h00, d)
        rd(2'h3);
        `CHK("unmapped rd", 8'h00, d)
        settle(1);
        `CHK("rdata idle", 8'h00, rdata_o)
        `CHK("ladder cfg", 6'h00, ladder_cfg_o)
        `CHK("code", 5'h00, ladder_code_o)
        `CHK("fixed cfg", 3'h1, fixed_cfg_o)
        `CHK("stable", 1'b0, fixed_ref_stable_o)
        `CHK("pin ctrl", 3'h0, pin_ctrl_o)
        $display("t_reset done");
    endtask

    task automatic t_ladder();
        logic [7:0] v;
        wr(2'h3, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            v = 8'h92 | 8'(i << 2) | 8'(i & 1);
            wr(2'h1, v);
            `CHK("cfg", {3'h4, 2'(i), 1'(i)}, ladder_cfg_o)
            rd(2'h1);
            `CHK("ladder rd", v & 8'hED, d)
        end
        wr(2'h2, 8'hFF);
        rd(2'h2);
        `CHK("level rd", 8'h1F, d)
        wr(2'h2, 8'h0A);
        settle(2);
        `CHK("code on", 5'h0A, ladder_code_o)
        $display("t_ladder done");
    endtask

    task automatic t_lowpower();
        wr(2'h1, 8'h40);
        settle(2);
        `CHK("enable off", 1'b0, ladder_cfg_o.ladder_enable)
        `CHK("code lps1", 5'h1F, ladder_code_o)
        wr(2'h1, 8'h00);
        settle(2);
        `CHK("code lps0", 5'h00, ladder_code_o)
        rd(2'h2);
        `CHK("level kept", 8'h0A, d)
        $display("t_lowpower done");
    endtask

    task automatic t_pin();
        @(posedge clk_i);
        pin_i <= 1'b1;
        settle(6);
        `CHK("pin read", 1'b1, pin_read_o)
        `CHK("pin ctrl off", 3'h0, pin_ctrl_o)
        wr(2'h1, 8'h20);
        settle(2);
        `CHK("pin ctrl on", 3'h7, pin_ctrl_o)
        `CHK("pin read zero", 1'b0, pin_read_o)
        wr(2'h1, 8'h00);
        settle(2);
        `CHK("pin ctrl back", 3'h0, pin_ctrl_o)
        `CHK("pin read back", 1'b1, pin_read_o)
        $display("t_pin done");
    endtask

    task automatic t_fixed();
        // Stable bit and low nibble set on purpose: both must be ignored
        wr(2'h0, 8'hCF);
        `CHK("fixed cfg", 3'h4, fixed_cfg_o)
        repeat (1249) @(posedge clk_i);
        #1 `CHK("not yet stable", 1'b0, fixed_ref_stable_o)
        settle(1);
        `CHK("stable", 1'b1, fixed_ref_stable_o)
        for (int g = 1; g < 4; g++) begin
            wr(2'h0, {2'h2, 2'(g), 4'h0});
            `CHK("gain", {1'b1, 2'(g)}, fixed_cfg_o)
            rd(2'h0);
            `CHK("fixed rd", {2'h3, 2'(g), 4'h0}, d)
        end
        wr(2'h0, 8'h10);
        settle(1);
        `CHK("stable drop", 1'b0, fixed_ref_stable_o)
        `CHK("fixed off", 3'h1, fixed_cfg_o)
        $display("t_fixed done");
    endtask

    task automatic t_reset_mid();
        wr(2'h1, 8'hAD);
        wr(2'h2, 8'h15);
        wr(2'h0, 8'hB0);
        @(posedge clk_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        pin_i <= 1'b0;
        t_reset();
        $display("t_reset_mid done");
    endtask

    // ==========================================================
    // Timeout and main sequence
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            close_out();
        end
    end

    initial begin
        resetn_i = 1'b0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        pin_i = 1'b0;
        addr_i = 2'h0;
        wdata_i = 8'h00;
        repeat (8) @(posedge clk_i);
        resetn_i <= 1'b1;
        t_reset();
        t_ladder();
        t_lowpower();
        t_pin();
        t_fixed();
        t_reset_mid();
        close_out();
    end
endmodule
